// ===== hw/nvram_host.sv
// Purpose: Host controller driving an asynchronous battery-backed memory
// Assumes: Device pins synchronous to MCLK
// Notes: One access at a time; request taken when ready
`timescale 1ns/100ps
`default_nettype none
module nvram_host
  import nvram_host_pkg::*;
#(
  parameter int RECOVERY = nvram_host_pkg::ACCESS_RECOVERY_CYCLES
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [nvram_host_pkg::ADDR_W-1:0] REQ_ADDR,
  input wire logic [nvram_host_pkg::DATA_W-1:0] REQ_WDATA,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [nvram_host_pkg::DATA_W-1:0] RSP_RDATA,
  output logic MEM_READY,
  output logic [nvram_host_pkg::ADDR_W-1:0] BYTE_ADDRESS,
  input wire logic [nvram_host_pkg::DATA_W-1:0] DATA_LINE_IN,
  output logic [nvram_host_pkg::DATA_W-1:0] DATA_LINE_OUT,
  output logic DATA_LINE_OE,
  output logic SELECT_N,
  output logic WRITE_N,
  output logic OUT_EN_N,
  input wire logic SUP_RST_N
);
  import nvram_host_pkg::*;
  host_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic ready;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic rsp_reg;
  logic sel_n_reg;
  logic we_n_reg;
  logic oe_n_reg;
  logic dq_oe_reg;
  logic wr_reg;

  nvram_reset_watch #(
    .RECOVERY(RECOVERY)
  ) u_watch (
    .clk(MCLK),
    .rst(SYS_RST),
    .sup_rst_n(SUP_RST_N),
    .ready(ready)
  );

  assign REQ_READY = (state_reg == ST_IDLE) && ready;
  assign MEM_READY = ready;
  assign BYTE_ADDRESS = addr_reg;
  assign DATA_LINE_OUT = wdata_reg;
  assign DATA_LINE_OE = dq_oe_reg;
  assign SELECT_N = sel_n_reg;
  assign WRITE_N = we_n_reg;
  assign OUT_EN_N = oe_n_reg;
  assign RSP_VALID = rsp_reg;
  assign RSP_RDATA = rdata_reg;

  // Sequencer and strobes
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= ST_WAIT_RST;
      cnt_reg <= '0;
      sel_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      dq_oe_reg <= 1'b0;
      wr_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_WAIT_RST: begin
          // [R14] Hold off access
          if (ready) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (!ready) begin
            state_reg <= ST_WAIT_RST;
          end else if (REQ_VALID) begin
            wr_reg <= REQ_WRITE;
            dq_oe_reg <= REQ_WRITE;
            cnt_reg <= '0;
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // [R07] Address settled first
          if (cnt_reg >= CNT_W'(SETUP_CYCLES - 1)) begin
            cnt_reg <= '0;
            sel_n_reg <= 1'b0;
            if (wr_reg) begin
              // [R05] Both strobes fall
              we_n_reg <= 1'b0;
              state_reg <= ST_WRITE;
            end else begin
              // [R04] Read with write high
              oe_n_reg <= 1'b0;
              state_reg <= ST_READ;
            end
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_READ: begin
          // [R03] Wait access delay
          if (cnt_reg >= CNT_W'(ACCESS_CYCLES - 1)) begin
            cnt_reg <= '0;
            sel_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            state_reg <= ST_RECOVER;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_WRITE: begin
          // [R06] Strobes rise, data held
          if (cnt_reg >= CNT_W'(WRITE_CYCLES - 1)) begin
            cnt_reg <= '0;
            sel_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            state_reg <= ST_RECOVER;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_RECOVER: begin
          // [R08] Write strobe high recovery
          dq_oe_reg <= 1'b0;
          if (cnt_reg >= CNT_W'(RECOVERY_CYCLES - 1)) begin
            cnt_reg <= '0;
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= ST_WAIT_RST;
        end
      endcase
    end
  end

  // Request capture
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      addr_reg <= '0;
      wdata_reg <= '0;
    end else if (REQ_READY && REQ_VALID) begin
      // [R02] Byte address latched
      addr_reg <= REQ_ADDR;
      wdata_reg <= REQ_WDATA;
    end
  end

  // Read data capture
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_reg <= '0;
      rsp_reg <= 1'b0;
    end else begin
      rsp_reg <= 1'b0;
      // [R20] Sample stored byte
      if (state_reg == ST_READ && cnt_reg >= CNT_W'(ACCESS_CYCLES - 1)) begin
        rdata_reg <= DATA_LINE_IN;
        rsp_reg <= 1'b1;
      end else if (state_reg == ST_WRITE &&
                   cnt_reg >= CNT_W'(WRITE_CYCLES - 1)) begin
        rsp_reg <= 1'b1;
      end
    end
  end

  // [R09] Output enable high writing
  property p_oe_off_write;
    @(posedge MCLK) disable iff (SYS_RST) !WRITE_N |-> OUT_EN_N;
  endproperty
  a_oe_off_write: assert property (p_oe_off_write) else $error("oe low in write"); // [R09]
  // [R01] No drive during read
  property p_no_drive_read;
    @(posedge MCLK) disable iff (SYS_RST) !OUT_EN_N |-> !DATA_LINE_OE;
  endproperty
  a_no_drive_read: assert property (p_no_drive_read) else $error("contention"); // [R01]
  // [R07] Address stable in write
  property p_addr_stable;
    @(posedge MCLK) disable iff (SYS_RST)
      (!WRITE_N && !SELECT_N && !$past(WRITE_N)) |-> $stable(BYTE_ADDRESS);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("addr moved"); // [R07]
  // [R05] Write pulse length
  property p_write_len;
    @(posedge MCLK) disable iff (SYS_RST)
      $fell(WRITE_N) |-> (!WRITE_N && !SELECT_N)[*8] ##1
      (!WRITE_N && !SELECT_N)[*7] ##1 WRITE_N;
  endproperty
  a_write_len: assert property (p_write_len) else $error("write pulse"); // [R05]
  // [R06] Data held until end
  property p_data_hold;
    @(posedge MCLK) disable iff (SYS_RST)
      $rose(WRITE_N) |-> DATA_LINE_OE && $stable(DATA_LINE_OUT);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data hold"); // [R06]
  // [R08] Recovery before next
  property p_recovery;
    @(posedge MCLK) disable iff (SYS_RST)
      $rose(WRITE_N) |-> SELECT_N[*2];
  endproperty
  a_recovery: assert property (p_recovery) else $error("recovery"); // [R08]
  // [R14] No access before ready
  property p_no_early;
    @(posedge MCLK) disable iff (SYS_RST) !MEM_READY |-> !REQ_READY;
  endproperty
  a_no_early: assert property (p_no_early) else $error("early access"); // [R14]
  // [R03] Read strobe length
  property p_read_len;
    @(posedge MCLK) disable iff (SYS_RST)
      $fell(OUT_EN_N) |-> ##21 (OUT_EN_N && RSP_VALID);
  endproperty
  a_read_len: assert property (p_read_len) else $error("read length"); // [R03]
  c_read: cover property (@(posedge MCLK) $fell(OUT_EN_N));
  c_write: cover property (@(posedge MCLK) $fell(WRITE_N));
  c_ready: cover property (@(posedge MCLK) $rose(MEM_READY));
endmodule : nvram_host
`default_nettype wire

// ===== hw/nvram_host_pkg.sv
// Purpose: Constants for the host controller of a byte-wide battery-backed memory
// Assumes: MCLK at 200 MHz
// Notes: Summary list below
// Summary of operation
// [R01] Strobes decode read, write, standby
// [R02] Seventeen address bits pick one byte
// [R03] Read data valid after access delay
// [R04] Read whenever write high, select low
// [R05] Write starts at later falling strobe
// [R06] Write ends at earlier rising strobe
// [R07] Host holds address stable during write
// [R08] Host waits write recovery after write
// [R09] Host keeps output enable high writing
// [R10] Falling write strobe disables outputs
// [R11] Full access above 3.0V, protect 2.8V
// [R12] Protected: inputs ignored, outputs tri-stated
// [R13] Battery powers array below 2.5V
// [R14] Host waits recovery before first access
// [R15] Supervisor reset low on supply failure
// [R16] Reset held through power-up timeout
// [R17] Power-up timeout 225 to 525 ms; the device model uses RST_TIMEOUT_NS = 400 ns
// [R18] Battery enabled first time supply valid
// [R19] Supervisor reset is open drain
// [R20] Read returns byte last written
package nvram_host_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 5;
  // Access timing, ns
  localparam int ACCESS_DELAY_NS = 100;
  localparam int WRITE_PULSE_NS = 75;
  localparam int WRITE_RECOVERY_NS = 5;
  localparam int SETUP_NS = 5;
  // Recovery after reset release, ms
  localparam int ACCESS_RECOVERY_MS = 2;
  localparam int ACCESS_CYCLES =
    (ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int WRITE_CYCLES =
    (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYCLES =
    (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int SETUP_CYCLES = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_RECOVERY_CYCLES = ACCESS_RECOVERY_MS * 200000;
  localparam int CNT_W = 20;
  typedef enum logic [2:0] {
    ST_WAIT_RST, ST_IDLE, ST_SETUP, ST_READ, ST_WRITE, ST_RECOVER
  } host_state_t;
endpackage : nvram_host_pkg

// ===== hw/nvram_reset_watch.sv
// Purpose: Track supervisor reset and timed access recovery
// Assumes: Reset pin pulled high externally
// Notes: Ready only after recovery count
`timescale 1ns/100ps
`default_nettype none
module nvram_reset_watch
  import nvram_host_pkg::*;
#(
  parameter int RECOVERY = ACCESS_RECOVERY_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sup_rst_n,
  output logic ready
);
  logic [CNT_W-1:0] cnt_reg;
  logic ready_reg;
  // [R14] Wait recovery interval
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      ready_reg <= 1'b0;
    end else if (!sup_rst_n) begin
      // [R15] Supply failure drops ready
      cnt_reg <= '0;
      ready_reg <= 1'b0;
    end else if (!ready_reg) begin
      if (cnt_reg >= CNT_W'(RECOVERY - 1)) begin
        ready_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
  assign ready = ready_reg;
endmodule : nvram_reset_watch
`default_nettype wire

// ===== tb/nvram_dev_model.sv
// Purpose: Behavioural battery-backed byte memory
// Assumes: Supply state given as a level
// Notes: Released data lines show inverse of last level
`timescale 1ns/100ps
`default_nettype none
module nvram_dev_model
  import nvram_host_pkg::*;
#(
  parameter int RST_TIMEOUT_NS = 400
) (
  input wire logic supply_ok,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic sel_n,
  input wire logic wr_n,
  input wire logic oe_n,
  input wire logic [DATA_W-1:0] host_q,
  input wire logic host_oe,
  output logic [DATA_W-1:0] bus,
  output logic rst_n
);
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] last = 8'h00;
  logic drive;
  logic drive_late;
  logic wr_act = 1'b0;
  logic batt_en = 1'b0;
  assign drive = supply_ok && !sel_n && wr_n && !oe_n;
  // Data valid only after access delay
  assign #(ACCESS_DELAY_NS) drive_late = drive;
  always @* begin
    if (host_oe) bus = host_q;
    else if (drive && drive_late) bus = mem.exists(addr) ? mem[addr] : ~last;
    else bus = ~last;
    if (host_oe || (drive && drive_late && mem.exists(addr))) last = bus;
  end
  always @* begin
    if (!supply_ok) wr_act = 1'b0;
    else if (!sel_n && !wr_n) wr_act = 1'b1;
  end
  always @(posedge sel_n or posedge wr_n) begin
    if (wr_act) mem[addr] = bus;
    wr_act = 1'b0;
  end
  always @(posedge supply_ok) batt_en = 1'b1;
  initial rst_n = 1'b0;
  always @(supply_ok) begin
    if (!supply_ok) rst_n = 1'b0;
    else #(RST_TIMEOUT_NS) rst_n = supply_ok;
  end
endmodule : nvram_dev_model
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the memory host
// Assumes: Recovery shortened to 16 cycles
// Notes: Reference model is an associative array
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import nvram_host_pkg::*;
  logic MCLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic REQ_VALID = 1'b0;
  logic REQ_WRITE = 1'b0;
  logic [ADDR_W-1:0] REQ_ADDR = '0;
  logic [DATA_W-1:0] REQ_WDATA = '0;
  logic REQ_READY, RSP_VALID, MEM_READY, DATA_LINE_OE;
  logic SELECT_N, WRITE_N, OUT_EN_N, SUP_RST_N, supply_ok = 1'b0;
  logic [DATA_W-1:0] RSP_RDATA, DATA_LINE_IN, DATA_LINE_OUT;
  logic [ADDR_W-1:0] BYTE_ADDRESS;
  logic [DATA_W-1:0] ref_mem [int];
  int error_cnt = 0;
  int comparisons = 0;
  int i;
  always #2.5 MCLK = ~MCLK;
  nvram_host #(.RECOVERY(16)) dut (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR),
    .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
    .RSP_RDATA(RSP_RDATA), .MEM_READY(MEM_READY),
    .BYTE_ADDRESS(BYTE_ADDRESS), .DATA_LINE_IN(DATA_LINE_IN),
    .DATA_LINE_OUT(DATA_LINE_OUT), .DATA_LINE_OE(DATA_LINE_OE),
    .SELECT_N(SELECT_N), .WRITE_N(WRITE_N), .OUT_EN_N(OUT_EN_N),
    .SUP_RST_N(SUP_RST_N));
  nvram_dev_model dev (.supply_ok(supply_ok), .addr(BYTE_ADDRESS),
    .sel_n(SELECT_N), .wr_n(WRITE_N), .oe_n(OUT_EN_N),
    .host_q(DATA_LINE_OUT), .host_oe(DATA_LINE_OE), .bus(DATA_LINE_IN),
    .rst_n(SUP_RST_N));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic results();
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    int n;
    logic bad;
    n = 0;
    bad = 1'b0;
    while (REQ_READY !== 1'b1 && n < 300) begin
      @(negedge MCLK);
      n++;
    end
    REQ_VALID = 1'b1;
    REQ_WRITE = wr;
    REQ_ADDR = a;
    REQ_WDATA = d;
    @(negedge MCLK);
    REQ_VALID = 1'b0;
    REQ_WDATA = ~d;
    n = 0;
    while (RSP_VALID !== 1'b1 && n < 100) begin
      if (SELECT_N === 1'b0 && BYTE_ADDRESS !== a) bad = 1'b1;
      if (wr && OUT_EN_N !== 1'b1) bad = 1'b1;
      @(negedge MCLK);
      n++;
    end
    check(n, SETUP_CYCLES + (wr ? WRITE_CYCLES : ACCESS_CYCLES));
    check(bad, 0);
    if (wr) ref_mem[a] = d;
    else if (ref_mem.exists(a)) check(RSP_RDATA, ref_mem[a]);
  endtask : access
  task automatic power_cycle();
    int n;
    n = 0;
    supply_ok = 1'b0;
    repeat (3) @(negedge MCLK);
    check({MEM_READY, REQ_READY}, 0);
    supply_ok = 1'b1;
    @(posedge SUP_RST_N);
    while (MEM_READY !== 1'b1 && n < 200) begin
      @(negedge MCLK);
      n++;
    end
    check(n >= 15 && n <= 19, 1);
  endtask : power_cycle
  initial begin
    #200000;
    error_cnt++;
    results();
  end
  initial begin
    void'($urandom(73));
    #1 supply_ok = 1'b1;
    repeat (4) @(negedge MCLK);
    SYS_RST = 1'b0;
    access(1'b1, 17'h00000, 8'ha5);
    access(1'b1, 17'h1ffff, 8'h3c);
    for (i = 0; i < 12; i++) begin
      access(1'b1, 17'($urandom), 8'($urandom));
      access(1'b0, REQ_ADDR, 8'h00);
    end
    access(1'b1, 17'h00000, 8'h5a);
    power_cycle();
    foreach (ref_mem[k]) access(1'b0, 17'(k), 8'h00);
    results();
  end
endmodule : tb_top
`default_nettype wire
